// *** shared/brake_seq_consts.vh ***
// constants for the mechanical brake sequencer
`ifndef BRAKE_SEQ_CONSTS_VH
`define BRAKE_SEQ_CONSTS_VH
// ==========================================
// register offsets
`define OFS_CTRL        8'h00
`define OFS_PRIME_TRQ   8'h04
`define OFS_PRIME_TIME  8'h08
`define OFS_PRIME_TOUT  8'h0C
`define OFS_REL_TIME    8'h10
`define OFS_CLOSE_TIME  8'h14
`define OFS_HOVER_TIME  8'h18
`define OFS_CLOSE_SPD   8'h1C
`define OFS_DISENG_TIME 8'h20
`define OFS_TERM_SEL    8'h24
`define OFS_STATUS      8'h28
// ==========================================
// control fields
`define CTRL_EN_BIT     0
`define CTRL_FB_BIT     1
`define CTRL_DIR_LSB    2
`define CTRL_CLR_BIT    8
// ==========================================
// direction codes
`define DIR_CW          2'h0
`define DIR_CCW         2'h1
`define DIR_REF         2'h2
// ==========================================
// status bits
`define ST_EN           0
`define ST_START        1
`define ST_FB_OPEN      2
`define ST_FB_CLOSED    3
`define ST_PRIME_ERR    11
`define ST_REL_TOUT     12
`define ST_CLOSE_TOUT   13
`define ST_BUSY         14
`define ST_BRAKE_OPEN   15
// ==========================================
// ranges and resets (percent, ms, 0.1 Hz)
`define TRQ_MAX         16'h00C8
`define TRQ_RST         16'h0064
`define PRIME_MAX       16'h1388
`define PRIME_RST       16'h00C8
`define PTOUT_MIN       16'h07D0
`define PTOUT_MAX       16'h2710
`define PTOUT_RST       16'h1388
`define RC_MIN          16'h0064
`define RC_MAX          16'h7530
`define RC_RST          16'h01F4
`define HOVER_MAX       16'hEA60
`define HOVER_RST       16'h0000
`define SPD_MAX         16'h00FA
`define SPD_RST         16'h0032
`define DIS_MAX         16'h1388
`define DIS_RST         16'h00C8
// ==========================================
// time base
`define CLK_HZ          100000000
`define TICK_MS         1
`endif

// *** rtl/mechanical_brake_sequencer.v ***
// mechanical brake sequencer with register port
`timescale 1ns/10ps
`include "brake_seq_consts.vh"

// Overview of operation
// - status bit 0 shows function enabled
// - status bit 1 shows start request present
// - bits 2,3 show open/closed contacts
// - bit 11 flags holding torque not reached
// - bit 12 flags open contact timeout
// - bit 13 flags closed contact timeout
// - bit 14 busy during open or close
// - bit 15 mirrors brake drive output
// - direction 0 cw, 1 ccw, 2 reference
// - priming torque 0..200 percent, default 100
// - priming interval 0..5 s, default 0.2
// - priming timeout warning, 2..10 s, default 5
// - release interval 0.1..30 s, default 0.5
// - close interval 0.1..30 s, default 0.5
// - hover 0..60 s before closing brake
// - drop output at closing speed 0..25 Hz
// - release holding torque over disengage time
// - open contact from selectable input terminal
// - closed contact from selectable input terminal
// - brake drive on selectable output terminal
// - energise only after torque and interval
// - hold speed ramp until open confirmed
module mechanical_brake_sequencer #(
	parameter TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS,
	parameter N_TERM      = 8
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [7:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [15:0] rdata,
	input  wire        start_req,
	input  wire        ref_negative,
	input  wire [15:0] motor_speed,
	input  wire [15:0] torque_actual,
	input  wire [7:0]  din,
	output reg  [7:0]  dout,
	output reg  [15:0] torque_cmd,
	output reg         torque_ccw,
	output reg         hold_active,
	output reg         speed_ramp_en
);

	// ==========================================
	// states
	localparam S_IDLE    = 3'd0;
	localparam S_PRIME   = 3'd1;
	localparam S_RELEASE = 3'd2;
	localparam S_RUN     = 3'd3;
	localparam S_HOVER   = 3'd4;
	localparam S_CLOSE   = 3'd5;
	localparam S_DISENG  = 3'd6;

	// ==========================================
	// clamp helper
	function [15:0] clamp;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			if (v < lo)
				clamp = lo;
			else if (v > hi)
				clamp = hi;
			else
				clamp = v;
		end
	endfunction

	// ==========================================
	// configuration registers
	reg        en_q;
	reg        fb_en_q;
	reg [1:0]  dir_q;
	reg [15:0] prime_trq_q;
	reg [15:0] prime_time_q;
	reg [15:0] prime_tout_q;
	reg [15:0] rel_time_q;
	reg [15:0] close_time_q;
	reg [15:0] hover_time_q;
	reg [15:0] close_spd_q;
	reg [15:0] diseng_time_q;
	reg [2:0]  open_sel_q;
	reg [2:0]  closed_sel_q;
	reg [2:0]  out_sel_q;
	wire       clr_err;

	assign clr_err = wr_en && addr == `OFS_CTRL && wdata[`CTRL_CLR_BIT];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q          <= 1'b0;
			fb_en_q       <= 1'b0;
			dir_q         <= `DIR_CW;
			prime_trq_q   <= `TRQ_RST;
			prime_time_q  <= `PRIME_RST;
			prime_tout_q  <= `PTOUT_RST;
			rel_time_q    <= `RC_RST;
			close_time_q  <= `RC_RST;
			hover_time_q  <= `HOVER_RST;
			close_spd_q   <= `SPD_RST;
			diseng_time_q <= `DIS_RST;
			open_sel_q    <= 3'h0;
			closed_sel_q  <= 3'h1;
			out_sel_q     <= 3'h0;
		end else if (wr_en) begin
			case (addr)
			`OFS_CTRL: begin
				en_q    <= wdata[`CTRL_EN_BIT];
				fb_en_q <= wdata[`CTRL_FB_BIT];
				// code 3 is not a direction: keep the old one
				if (wdata[`CTRL_DIR_LSB+1 -: 2] != 2'h3)
					dir_q <= wdata[`CTRL_DIR_LSB+1 -: 2];
			end
			`OFS_PRIME_TRQ:
				prime_trq_q <= clamp(wdata, 16'h0000, `TRQ_MAX);
			`OFS_PRIME_TIME:
				prime_time_q <= clamp(wdata, 16'h0000, `PRIME_MAX);
			`OFS_PRIME_TOUT:
				prime_tout_q <= clamp(wdata, `PTOUT_MIN, `PTOUT_MAX);
			`OFS_REL_TIME:
				rel_time_q <= clamp(wdata, `RC_MIN, `RC_MAX);
			`OFS_CLOSE_TIME:
				close_time_q <= clamp(wdata, `RC_MIN, `RC_MAX);
			`OFS_HOVER_TIME:
				hover_time_q <= clamp(wdata, 16'h0000, `HOVER_MAX);
			`OFS_CLOSE_SPD:
				close_spd_q <= clamp(wdata, 16'h0000, `SPD_MAX);
			`OFS_DISENG_TIME:
				diseng_time_q <= clamp(wdata, 16'h0000, `DIS_MAX);
			`OFS_TERM_SEL: begin
				open_sel_q   <= wdata[2:0];
				closed_sel_q <= wdata[6:4];
				out_sel_q    <= wdata[10:8];
			end
			default: begin
			end
			endcase
		end
	end

	// ==========================================
	// feedback terminal selection
	wire fb_open;
	wire fb_closed;

	assign fb_open   = din[open_sel_q];
	assign fb_closed = din[closed_sel_q];

	// ==========================================
	// millisecond tick
	reg [16:0] div_q;
	reg        tick_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= 17'h0_0000;
			tick_q <= 1'b0;
		end else if (div_q == TICK_CYCLES[16:0] - 17'h0_0001) begin
			div_q  <= 17'h0_0000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 17'h0_0001;
			tick_q <= 1'b0;
		end
	end

	// ==========================================
	// sequencer
	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [15:0] ms_q;
	reg [15:0] ptmo_q;
	reg        prime_err_q;
	reg        rel_tout_q;
	reg        close_tout_q;
	reg        brake_q;
	wire       trq_ok;
	wire       at_close_spd;
	wire       busy;

	assign trq_ok       = torque_actual >= prime_trq_q;
	assign at_close_spd = motor_speed <= close_spd_q;
	assign busy = state_q != S_IDLE && state_q != S_RUN;

	always @* begin
		state_d = state_q;
		case (state_q)
		S_IDLE:
			if (en_q && start_req)
				state_d = S_PRIME;
		S_PRIME:
			if (!start_req)
				state_d = S_IDLE;
			else if (trq_ok && ms_q >= prime_time_q)
				state_d = S_RELEASE;
		S_RELEASE:
			if (fb_en_q ? fb_open : ms_q >= rel_time_q)
				state_d = S_RUN;
		S_RUN:
			if (!start_req && at_close_spd)
				state_d = S_HOVER;
		S_HOVER:
			if (start_req)
				state_d = S_RUN;
			else if (ms_q >= hover_time_q)
				state_d = S_CLOSE;
		S_CLOSE:
			if (fb_en_q ? fb_closed : ms_q >= close_time_q)
				state_d = S_DISENG;
		S_DISENG:
			if (ms_q >= diseng_time_q)
				state_d = S_IDLE;
		default:
			state_d = S_IDLE;
		endcase
		if (!en_q)
			state_d = S_IDLE;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			ms_q    <= 16'h0000;
			ptmo_q  <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_d != state_q)
				ms_q <= 16'h0000;
			else if (tick_q && ms_q != 16'hFFFF)
				ms_q <= ms_q + 16'h0001;
			if (state_q != S_PRIME)
				ptmo_q <= 16'h0000;
			else if (tick_q && ptmo_q != 16'hFFFF)
				ptmo_q <= ptmo_q + 16'h0001;
		end
	end

	// ==========================================
	// error set conditions
	// flags only report, the sequence keeps waiting
	wire prime_err_set;
	wire rel_tout_set;
	wire close_tout_set;

	assign prime_err_set  = state_q == S_PRIME && !trq_ok &&
	                        ptmo_q >= prime_tout_q;
	assign rel_tout_set   = state_q == S_RELEASE && fb_en_q && !fb_open &&
	                        ms_q >= rel_time_q;
	assign close_tout_set = state_q == S_CLOSE && fb_en_q && !fb_closed &&
	                        ms_q >= close_time_q;

	// ==========================================
	// sticky error flags, set beats clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prime_err_q  <= 1'b0;
			rel_tout_q   <= 1'b0;
			close_tout_q <= 1'b0;
		end else begin
			if (prime_err_set)
				prime_err_q <= 1'b1;
			else if (clr_err)
				prime_err_q <= 1'b0;
			if (rel_tout_set)
				rel_tout_q <= 1'b1;
			else if (clr_err)
				rel_tout_q <= 1'b0;
			if (close_tout_set)
				close_tout_q <= 1'b1;
			else if (clr_err)
				close_tout_q <= 1'b0;
		end
	end

	// ==========================================
	// disengage ramp
	// the count of the close state must not leak in:
	// it would wrap the command on the entry edge
	wire [15:0] ramp_ms;
	wire [31:0] ramp_prod;
	wire [31:0] ramp_drop;

	assign ramp_ms   = (state_q == S_DISENG) ? ms_q : 16'h0000;
	assign ramp_prod = {16'h0000, prime_trq_q} * {16'h0000, ramp_ms};
	assign ramp_drop = ramp_prod / {16'h0000, diseng_time_q};

	// ==========================================
	// drive outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brake_q       <= 1'b0;
			dout          <= 8'h00;
			torque_cmd    <= 16'h0000;
			torque_ccw    <= 1'b0;
			hold_active   <= 1'b0;
			speed_ramp_en <= 1'b0;
		end else begin
			brake_q <= state_d == S_RELEASE || state_d == S_RUN ||
			           state_d == S_HOVER;
			dout <= 8'h00;
			if (state_d == S_RELEASE || state_d == S_RUN ||
			    state_d == S_HOVER)
				dout[out_sel_q] <= 1'b1;
			speed_ramp_en <= state_d == S_RUN;
			hold_active   <= state_d != S_IDLE;
			if (state_d == S_IDLE)
				torque_cmd <= 16'h0000;
			else if (state_d == S_DISENG && diseng_time_q != 16'h0000)
				torque_cmd <= prime_trq_q - ramp_drop[15:0];
			else
				torque_cmd <= prime_trq_q;
			if (state_q == S_IDLE)
				case (dir_q)
				`DIR_CCW: torque_ccw <= 1'b1;
				`DIR_REF: torque_ccw <= ref_negative;
				default:  torque_ccw <= 1'b0;
				endcase
		end
	end

	// ==========================================
	// status word and read port
	wire [15:0] status;

	assign status = {brake_q,
	                 busy,
	                 close_tout_q, rel_tout_q, prime_err_q,
	                 7'h00,
	                 fb_en_q & fb_closed,
	                 fb_en_q & fb_open,
	                 start_req,
	                 en_q};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (rd_en) begin
			case (addr)
			`OFS_CTRL:
				rdata <= {8'h00, 4'h0, dir_q, fb_en_q, en_q};
			`OFS_PRIME_TRQ:   rdata <= prime_trq_q;
			`OFS_PRIME_TIME:  rdata <= prime_time_q;
			`OFS_PRIME_TOUT:  rdata <= prime_tout_q;
			`OFS_REL_TIME:    rdata <= rel_time_q;
			`OFS_CLOSE_TIME:  rdata <= close_time_q;
			`OFS_HOVER_TIME:  rdata <= hover_time_q;
			`OFS_CLOSE_SPD:   rdata <= close_spd_q;
			`OFS_DISENG_TIME: rdata <= diseng_time_q;
			`OFS_TERM_SEL:
				rdata <= {5'h00, out_sel_q, 1'b0, closed_sel_q,
				          1'b0, open_sel_q};
			`OFS_STATUS:      rdata <= status;
			default:          rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

endmodule // mechanical_brake_sequencer

// *** tb/brake_seq_chk.sv ***
// port checker for the brake sequencer
`timescale 1ns/10ps
module brake_seq_chk (
	input logic        clk,
	input logic        rst_n,
	input logic [7:0]  addr,
	input logic        rd_en,
	input logic [15:0] rdata,
	input logic        start_req,
	input logic [15:0] motor_speed,
	input logic [7:0]  dout,
	input logic [15:0] torque_cmd,
	input logic        hold_active,
	input logic        speed_ramp_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// status reads
	sequence s_rd; rd_en && addr == 8'h28 ##1 1'b1; endsequence
	property p_spare; s_rd |-> rdata[10:4] == 7'h00; endproperty
	a_spare: assert property (p_spare) else $error("spare set");
	property p_start; s_rd |-> rdata[1] == $past(start_req); endproperty
	a_start: assert property (p_start) else $error("start bit");
	property p_open; s_rd |-> rdata[15] == $past(dout[0]); endproperty
	a_open: assert property (p_open) else $error("open bit");
	// ==========
	// brake sequence
	sequence s_drop; $fell(dout[0]); endsequence
	property p_rel; $rose(dout[0]) |-> hold_active; endproperty
	a_rel: assert property (p_rel) else $error("early release");
	property p_ramp;
		$rose(speed_ramp_en) |-> dout[0] && hold_active;
	endproperty
	a_ramp: assert property (p_ramp) else $error("early ramp");
	property p_spd;
		s_drop |-> $past(motor_speed) <= 16'h0032 && !$past(start_req);
	endproperty
	a_spd: assert property (p_spd) else $error("close speed");
	property p_hold; s_drop |-> hold_active [*3]; endproperty
	a_hold: assert property (p_hold) else $error("hold lost");
	property p_dis;
		hold_active && !dout[0] && !start_req && $past(hold_active)
			|-> torque_cmd <= $past(torque_cmd);
	endproperty
	a_dis: assert property (p_dis) else $error("torque rise");
endmodule // brake_seq_chk

// *** tb/brake_model.sv ***
// brake with open and closed contacts
`timescale 1ns/10ps
module brake_model #(
	parameter int DLY = 20
) (
	input  logic clk,
	input  logic rst_n,
	input  logic drive,
	input  logic stuck,
	output logic open_fb,
	output logic closed_fb
);
	int cnt;
	// ==========
	// contact travel
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			open_fb <= 1'b0;
			closed_fb <= 1'b1;
		end else if (!stuck && (drive != open_fb || drive == closed_fb)) begin
			cnt <= cnt + 1;
			if (drive)
				closed_fb <= 1'b0;
			else
				open_fb <= 1'b0;
			if (cnt == DLY) begin
				cnt <= 0;
				open_fb <= drive;
				closed_fb <= !drive;
			end
		end
	end
endmodule // brake_model

// *** tb/tb_mechanical_brake_sequencer.sv ***
// self-checking bench for the brake sequencer
`timescale 1ns/10ps
module tb_mechanical_brake_sequencer;
	logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic        start_req = 1'b0, ref_negative = 1'b0, stuck = 1'b0;
	logic [7:0]  addr = 8'h00, din, dout;
	logic [15:0] wdata = 16'h0000, motor_speed = 16'h0000, rdata, v;
	logic [15:0] torque_actual = 16'h0000, torque_cmd;
	logic        torque_ccw, hold_active, speed_ramp_en, open_fb, closed_fb;
	int          mismatches = 0, samples_checked = 0, n;
	assign din = {6'h00, closed_fb, open_fb};
	always #5 clk = ~clk;
	mechanical_brake_sequencer #(.TICK_CYCLES(10))
		mechanical_brake_sequencer_inst (.clk, .rst_n, .addr, .wdata, .wr_en,
		.rd_en, .rdata, .start_req, .ref_negative, .motor_speed,
		.torque_actual, .din, .dout, .torque_cmd, .torque_ccw, .hold_active,
		.speed_ramp_en);
	brake_model brake_model_inst (.clk, .rst_n, .drive(dout[0]), .stuck,
		.open_fb, .closed_fb);
	// ==========
	// bus and compare
	task automatic chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic st(input logic [15:0] m, e);
		rd(8'h28);
		chk(v & m, e);
	endtask
	function automatic bit hit(input int c);
		case (c)
			0: return dout[0] === 1'b1;
			1: return dout[0] === 1'b0;
			2: return speed_ramp_en === 1'b1;
			default: return hold_active === 1'b0;
		endcase
	endfunction
	task automatic wt(input int c, lim);
		for (n = 0; n < lim && !hit(c); n++) begin
			@(posedge clk);
			#1;
		end
		if (n >= lim) begin
			mismatches++;
			$display("mismatch t=%0t wait %0d timed out", $time, c);
			close_out;
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_regs;
		st(16'hFFFF, 16'h0000);
		wr(8'h28, 16'hFFFF);
		st(16'hFFFF, 16'h0000);
		rd(8'h40);
		chk(v, 16'h0000);
		$display("regs done");
	endtask
	task automatic t_dir;
		for (int i = 0; i < 3; i++) begin
			ref_negative <= (i != 1);
			wr(8'h00, {12'h000, i[1:0], 2'h1});
			start_req <= 1'b1;
			repeat (5) @(posedge clk);
			chk({15'h0000, torque_ccw}, {15'h0000, i != 0});
			chk(torque_cmd, 16'h0064);
			st(16'hC803, 16'h4003);
			start_req <= 1'b0;
			repeat (5) @(posedge clk);
			chk({15'h0000, hold_active}, 16'h0000);
		end
		$display("direction done");
	endtask
	task automatic t_prime;
		wr(8'h0C, 16'h07D0);
		start_req <= 1'b1;
		repeat (19800) @(posedge clk);
		st(16'h8800, 16'h0000);
		repeat (400) @(posedge clk);
		st(16'h8800, 16'h0800);
		start_req <= 1'b0;
		$display("priming done");
	endtask
	task automatic t_open;
		stuck <= 1'b1;
		wr(8'h10, 16'h0064);
		wr(8'h00, 16'h0003);
		torque_actual <= 16'h0064;
		start_req <= 1'b1;
		wt(0, 4000);
		chk({15'h0000, n > 1980}, 16'h0001);
		repeat (1200) @(posedge clk);
		st(16'hF00F, 16'hD00B);
		chk({15'h0000, speed_ramp_en}, 16'h0000);
		stuck <= 1'b0;
		wt(2, 100);
		st(16'hF00F, 16'h9007);
		$display("open done");
	endtask
	task automatic t_close;
		wr(8'h14, 16'h0064);
		start_req <= 1'b0;
		motor_speed <= 16'h0033;
		repeat (50) @(posedge clk);
		chk({15'h0000, dout[0]}, 16'h0001);
		stuck <= 1'b1;
		motor_speed <= 16'h0032;
		wt(1, 100);
		repeat (1200) @(posedge clk);
		st(16'hF00F, 16'h7005);
		chk(torque_cmd, 16'h0064);
		stuck <= 1'b0;
		wt(3, 3000);
		chk({15'h0000, n > 1980}, 16'h0001);
		chk(torque_cmd, 16'h0000);
		wr(8'h00, 16'h0103);
		st(16'hFFFF, 16'h0009);
		$display("close done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_dir;
		t_prime;
		t_open;
		t_close;
		close_out;
	end
endmodule // tb_mechanical_brake_sequencer
bind mechanical_brake_sequencer brake_seq_chk brake_seq_chk_inst (.clk,
	.rst_n, .addr, .rd_en, .rdata, .start_req, .motor_speed, .dout,
	.torque_cmd, .hold_active, .speed_ramp_en);
